// [hw/ssl_forward_stage.sv]
// Service, rule-action and source-address stages of the switch analyzer
`timescale 1ns/1ps
// What this block does
// - Per-service forced flag and port mask, 256.
// - Forced: service mask, then source, aggregation filters.
// - Not forced: drop ports cleared in mask.
// - Actions applied in fixed documented order.
// - CPU copy sets selected queue bit.
// - First-hit copy when hit counter is zero.
// - Action learn-disable sets suppress flag.
// - First lookup selects policer, may be exclusive.
// - Mask mode: none, permit, policy, redirect.
// - Mirror enable marks frame for mirroring.
// - Backbone select picks backbone or customer table.
// - Suppress flag skips all learning.
// - Normal learn: absent or unlocked moved, under cap.
// - Same conditions over cap: limit-exceeding learn.
// - Locked entry moved: locked port-move frame.
// - Learning needs enable, no suppress, not policed.
// - Automatic learning inserts entry into searched table.
// - Learn discard clears destination set.
// - Learn to CPU adds port and queue.
// - Limit discard clears; limit CPU adds port, queue.
// - Locked-move discard clears; CPU adds port, queue.
// - Entry discard and copy flags, unless global disable bit set.
module ssl_forward_stage
    import ssl_pkg::*;
#(
    parameter int PORT_COUNT = SSL_PORTS,
    parameter int SERVICE_COUNT = SSL_SERVICES
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire ssl_frame_t FRAME_IN,
    input wire ssl_action_t ACTION_IN,
    input wire ssl_learn_t LEARN_IN,
    input wire logic [SSL_AW-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output ssl_result_t RESULT_OUT,
    output logic [31:0] REG_RDATA
);
    // Carrier widths are fixed by the package
    if (PORT_COUNT != SSL_PORTS || SERVICE_COUNT != SSL_SERVICES) begin : g_bad_count
        $error("Port or service count differs from the frame carrier widths");
    end

    // Configuration storage
    logic [SSL_PORTS:0] service_tbl_q [SERVICE_COUNT];
    logic [SSL_V_BITS-1:0] virtual_port_cfg_q [SSL_VPORTS];
    logic [31:0] global_q;
    logic [SSL_CNTW-1:0] cnt_normal_q, cnt_limit_q, cnt_locked_q, cnt_frames_q;
    logic [31:0] rdata_q;

    logic svc_hit_w, virtual_port_hit_w;
    logic [SSL_SW-1:0] svc_idx_w;
    logic [SSL_VW-1:0] virtual_port_idx_w;

    assign svc_hit_w = REG_ADDR >= SSL_OFS_SERVICE && REG_ADDR < SSL_OFS_SERVICE_END;
    assign virtual_port_hit_w = REG_ADDR >= SSL_OFS_VIRTUAL_PORT && REG_ADDR < SSL_OFS_VIRTUAL_PORT_END;
    assign svc_idx_w = REG_ADDR[SSL_SW+1:2];
    assign virtual_port_idx_w = REG_ADDR[SSL_VW+1:2];

    // Register writes
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            global_q <= SSL_GLOBAL_RST;
            for (int i = 0; i < SSL_VPORTS; i++) begin
                virtual_port_cfg_q[i] <= '0;
            end
            for (int i = 0; i < SERVICE_COUNT; i++) begin
                service_tbl_q[i] <= '0;
            end
        end else if (REG_WR) begin
            if (REG_ADDR == SSL_OFS_GLOBAL) begin
                global_q <= REG_WDATA;
            end else if (virtual_port_hit_w) begin
                virtual_port_cfg_q[virtual_port_idx_w] <= REG_WDATA[SSL_V_BITS-1:0];
            end else if (svc_hit_w) begin
                service_tbl_q[svc_idx_w] <= {REG_WDATA[SSL_S_FORCE],
                                             REG_WDATA[SSL_PORTS-1:0]};
            end
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= '0;
        end else if (REG_RD) begin
            if (REG_ADDR == SSL_OFS_GLOBAL) begin
                rdata_q <= global_q;
            end else if (REG_ADDR == SSL_OFS_STATUS) begin
                rdata_q <= {cnt_frames_q, cnt_locked_q, cnt_limit_q, cnt_normal_q};
            end else if (virtual_port_hit_w) begin
                rdata_q <= 32'(virtual_port_cfg_q[virtual_port_idx_w]);
            end else if (svc_hit_w) begin
                rdata_q <= 32'(service_tbl_q[svc_idx_w][SSL_PORTS-1:0])
                    | (32'(service_tbl_q[svc_idx_w][SSL_PORTS]) << SSL_S_FORCE);
            end else begin
                rdata_q <= '0;
            end
        end else begin
            rdata_q <= '0;
        end
    end

    assign REG_RDATA = rdata_q;

    // Stage 1: service forwarding
    ssl_frame_t s1_frame_q;
    ssl_action_t s1_act_q;
    ssl_learn_t s1_lrn_q;
    ssl_frame_t s1_frame_d;
    logic [SSL_PORTS:0] svc_entry_w;
    logic forced_service_fwd_enable;
    ssl_ports_t service_egress_ports;

    assign svc_entry_w = service_tbl_q[FRAME_IN.service_index];
    assign forced_service_fwd_enable = svc_entry_w[SSL_PORTS];
    assign service_egress_ports = svc_entry_w[SSL_PORTS-1:0];

    always_comb begin
        s1_frame_d = FRAME_IN;
        if (forced_service_fwd_enable) begin
            s1_frame_d.destination_port_set = service_egress_ports
                & FRAME_IN.src_filter & FRAME_IN.aggr_filter;
            s1_frame_d.post_dmac_filter = FRAME_IN.src_filter & FRAME_IN.aggr_filter;
        end else begin
            s1_frame_d.destination_port_set = FRAME_IN.destination_port_set
                & service_egress_ports;
            s1_frame_d.post_dmac_filter = FRAME_IN.post_dmac_filter & service_egress_ports;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            s1_frame_q <= '0;
            s1_act_q <= '0;
            s1_lrn_q <= '0;
        end else begin
            s1_frame_q <= s1_frame_d;
            s1_act_q <= ACTION_IN;
            s1_lrn_q <= LEARN_IN;
        end
    end

    // Stage 2: rule action handling, in table order
    ssl_result_t s2_d, s2_q;
    ssl_learn_t s2_lrn_q;

    always_comb begin
        s2_d = '0;
        s2_d.valid = s1_frame_q.valid;
        s2_d.destination_port_set = s1_frame_q.destination_port_set;
        s2_d.cpu_queue_set = s1_frame_q.cpu_queue_set;
        s2_d.learn_suppress_flag = s1_frame_q.learn_suppress_flag;
        if (s1_act_q.hit) begin
            if (s1_act_q.action_cpu_copy) begin
                s2_d.cpu_queue_set[s1_act_q.action_cpu_queue_sel] = 1'b1;
            end
            if (s1_act_q.action_first_hit_copy && s1_act_q.rule_hit_counter == '0) begin
                s2_d.cpu_queue_set[s1_act_q.action_cpu_queue_sel] = 1'b1;
            end
            if (s1_act_q.learn_suppress) begin
                s2_d.learn_suppress_flag = 1'b1;
            end
            if (s1_act_q.first_lookup) begin
                s2_d.policer_on = s1_act_q.action_policer_enable;
                s2_d.policer_select = s1_act_q.action_policer_enable
                    ? s1_act_q.action_policer_select : '0;
                s2_d.rule_policer_exclusive = s1_act_q.action_rule_policer_exclusive;
            end
            case (s1_act_q.mask_mode)
                SSL_MM_PERMIT: begin
                    s2_d.destination_port_set = s2_d.destination_port_set
                        & s1_act_q.port_mask;
                end
                SSL_MM_POLICY: begin
                    s2_d.destination_port_set = s1_act_q.port_mask
                        & s1_frame_q.post_dmac_filter;
                end
                SSL_MM_REDIRECT: begin
                    s2_d.destination_port_set = s1_act_q.port_mask;
                end
                default: begin
                    s2_d.destination_port_set = s2_d.destination_port_set;
                end
            endcase
            s2_d.mirror = s1_act_q.action_mirror_flag;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            s2_q <= '0;
            s2_lrn_q <= '0;
        end else begin
            s2_q <= s2_d;
            s2_lrn_q <= s1_lrn_q;
        end
    end

    // Stage 3: source-address analysis
    ssl_result_t s3_d, out_q;
    logic [SSL_V_BITS-1:0] vcfg_w;
    logic learn_gate, moved, normal_cond, normal_lf, limit_lf, locked_lf, flags_on;

    assign vcfg_w = virtual_port_cfg_q[s2_lrn_q.virtual_port];
    assign moved = s2_lrn_q.entry_destination_index != s2_lrn_q.logical_port;
    assign learn_gate = vcfg_w[SSL_V_LEARN] && !s2_q.learn_suppress_flag
        && !s2_lrn_q.policed;
    assign normal_cond = !s2_lrn_q.entry_found
        || (!s2_lrn_q.entry_locked && moved);
    assign normal_lf = s2_q.valid && learn_gate && normal_cond
        && !s2_lrn_q.learned_entry_cap;
    assign limit_lf = s2_q.valid && learn_gate && normal_cond
        && s2_lrn_q.learned_entry_cap;
    assign locked_lf = s2_q.valid && learn_gate && s2_lrn_q.entry_found
        && s2_lrn_q.entry_locked && moved;
    assign flags_on = !global_q[SSL_G_FLAGS_OFF];

    always_comb begin
        s3_d = s2_q;
        s3_d.backbone_table_select = vcfg_w[SSL_V_BB];
        s3_d.normal_learn = normal_lf;
        s3_d.limit_learn = limit_lf;
        s3_d.locked_move = locked_lf;
        s3_d.insert_entry = normal_lf && vcfg_w[SSL_V_HW];
        if (normal_lf) begin
            if (vcfg_w[SSL_V_DROP]) begin
                s3_d.destination_port_set = '0;
            end
            if (vcfg_w[SSL_V_CPU]) begin
                s3_d.destination_port_set[SSL_CPU_PORT] = 1'b1;
                s3_d.cpu_queue_set[global_q[SSL_G_LRNQ +: SSL_QW]] = 1'b1;
            end
        end
        if (limit_lf) begin
            if (vcfg_w[SSL_V_LIMDROP]) begin
                s3_d.destination_port_set = '0;
            end
            if (vcfg_w[SSL_V_LIMCPU]) begin
                s3_d.destination_port_set[SSL_CPU_PORT] = 1'b1;
                s3_d.cpu_queue_set[global_q[SSL_G_LRNQ +: SSL_QW]] = 1'b1;
            end
        end
        if (locked_lf) begin
            if (vcfg_w[SSL_V_LMDROP]) begin
                s3_d.destination_port_set = '0;
            end
            if (vcfg_w[SSL_V_LMCPU]) begin
                s3_d.destination_port_set[SSL_CPU_PORT] = 1'b1;
                s3_d.cpu_queue_set[global_q[SSL_G_LMQ +: SSL_QW]] = 1'b1;
            end
        end
        if (s2_q.valid && s2_lrn_q.entry_found && flags_on) begin
            if (s2_lrn_q.source_entry_discard) begin
                s3_d.destination_port_set = '0;
            end
            if (s2_lrn_q.source_entry_cpu_copy) begin
                s3_d.cpu_queue_set[global_q[SSL_G_COPYQ +: SSL_QW]] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            out_q <= '0;
        end else begin
            out_q <= s3_d;
        end
    end

    assign RESULT_OUT = out_q;

    // Status counters, wrapping
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            cnt_normal_q <= '0;
            cnt_limit_q <= '0;
            cnt_locked_q <= '0;
            cnt_frames_q <= '0;
        end else begin
            cnt_normal_q <= cnt_normal_q + SSL_CNTW'(normal_lf);
            cnt_limit_q <= cnt_limit_q + SSL_CNTW'(limit_lf);
            cnt_locked_q <= cnt_locked_q + SSL_CNTW'(locked_lf);
            cnt_frames_q <= cnt_frames_q + SSL_CNTW'(s2_q.valid);
        end
    end

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    sequence seq_forced_in;
        FRAME_IN.valid && forced_service_fwd_enable;
    endsequence

    sequence seq_plain_in;
        FRAME_IN.valid && !forced_service_fwd_enable;
    endsequence

    AST_FORCED_MASK: assert property (
        seq_forced_in |=> s1_frame_q.destination_port_set
            == ($past(service_egress_ports) & $past(FRAME_IN.src_filter)
                & $past(FRAME_IN.aggr_filter)))
        else $error("Forced service result wrong");

    AST_SERVICE_LIMIT: assert property (
        seq_plain_in |=> (s1_frame_q.destination_port_set
            & ~$past(service_egress_ports)) == '0)
        else $error("Service mask did not restrict set");

    AST_CPU_COPY: assert property (
        (s1_act_q.hit && s1_act_q.action_cpu_copy && s1_frame_q.valid)
        |-> ##2 RESULT_OUT.cpu_queue_set[$past(s1_act_q.action_cpu_queue_sel, 2)])
        else $error("CPU copy queue bit missing");

    AST_FIRST_HIT: assert property (
        (s1_act_q.hit && s1_act_q.action_first_hit_copy && s1_act_q.rule_hit_counter == '0)
        |=> s2_q.cpu_queue_set[$past(s1_act_q.action_cpu_queue_sel)])
        else $error("First hit copy missing");

    AST_LEARN_OFF: assert property (
        (s1_act_q.hit && s1_act_q.learn_suppress) |=> s2_q.learn_suppress_flag
            ##1 !out_q.normal_learn && !out_q.insert_entry)
        else $error("Suppressed frame still learned");

    AST_REDIRECT: assert property (
        (s1_act_q.hit && s1_act_q.mask_mode == SSL_MM_REDIRECT)
        |=> s2_q.destination_port_set == $past(s1_act_q.port_mask))
        else $error("Redirect mask not applied");

    AST_MIRROR: assert property (
        (s1_act_q.hit && s1_act_q.action_mirror_flag) |-> ##2 RESULT_OUT.mirror)
        else $error("Mirror mark lost");

    AST_CLASS_EXCL: assert property (
        !(s3_d.normal_learn && s3_d.limit_learn) && !(s3_d.normal_learn && s3_d.locked_move))
        else $error("Learn classes overlap");

    AST_LEARN_DROP: assert property (
        (normal_lf && vcfg_w[SSL_V_DROP] && !vcfg_w[SSL_V_CPU])
        |=> RESULT_OUT.destination_port_set == '0)
        else $error("Learn discard left ports set");

    AST_KILL: assert property (
        (s2_q.valid && s2_lrn_q.entry_found && flags_on && s2_lrn_q.source_entry_discard)
        |=> RESULT_OUT.destination_port_set == '0)
        else $error("Source discard not applied");

    AST_LATENCY: assert property (
        FRAME_IN.valid |-> ##3 RESULT_OUT.valid)
        else $error("Result not three cycles after frame");
endmodule : ssl_forward_stage

// [common/ssl_pkg.sv]
// Shared constants, register map and frame carriers of the forwarding stage
package ssl_pkg;
    localparam int SSL_PORTS = 12;
    localparam int SSL_CPU_PORT = 11;
    localparam int SSL_QUEUES = 8;
    localparam int SSL_QW = 3;
    localparam int SSL_SERVICES = 256;
    localparam int SSL_SW = 8;
    localparam int SSL_VPORTS = 16;
    localparam int SSL_VW = 4;
    localparam int SSL_LPW = 6;
    localparam int SSL_POLW = 8;
    localparam int SSL_HITW = 16;
    localparam int SSL_AW = 12;
    localparam int SSL_CNTW = 8;

    // Register byte offsets
    localparam logic [SSL_AW-1:0] SSL_OFS_GLOBAL = 12'h000;
    localparam logic [SSL_AW-1:0] SSL_OFS_STATUS = 12'h004;
    localparam logic [SSL_AW-1:0] SSL_OFS_VIRTUAL_PORT = 12'h100;
    localparam logic [SSL_AW-1:0] SSL_OFS_SERVICE = 12'h400;
    localparam logic [SSL_AW-1:0] SSL_OFS_VIRTUAL_PORT_END = 12'h140;
    localparam logic [SSL_AW-1:0] SSL_OFS_SERVICE_END = 12'h800;

    // Global control fields
    localparam int SSL_G_LRNQ = 0;
    localparam int SSL_G_LMQ = 4;
    localparam int SSL_G_COPYQ = 8;
    localparam int SSL_G_FLAGS_OFF = 16;
    localparam logic [31:0] SSL_GLOBAL_RST = 32'h0000_0000;

    // Service entry fields
    localparam int SSL_S_FORCE = 16;

    // Virtual port profile fields
    localparam int SSL_V_LEARN = 0;
    localparam int SSL_V_HW = 1;
    localparam int SSL_V_CPU = 2;
    localparam int SSL_V_DROP = 3;
    localparam int SSL_V_LIMCPU = 4;
    localparam int SSL_V_LIMDROP = 5;
    localparam int SSL_V_LMCPU = 6;
    localparam int SSL_V_LMDROP = 7;
    localparam int SSL_V_BB = 8;
    localparam int SSL_V_BITS = 9;

    // Status counter fields
    localparam int SSL_ST_NORMAL = 0;
    localparam int SSL_ST_LIMIT = 8;
    localparam int SSL_ST_LOCKED = 16;
    localparam int SSL_ST_FRAMES = 24;

    typedef enum logic [1:0] {
        SSL_MM_NONE,
        SSL_MM_PERMIT,
        SSL_MM_POLICY,
        SSL_MM_REDIRECT
    } ssl_mask_mode_t;

    typedef logic [SSL_PORTS-1:0] ssl_ports_t;

    typedef struct packed {
        logic valid;
        logic [SSL_SW-1:0] service_index;
        ssl_ports_t destination_port_set;
        ssl_ports_t post_dmac_filter;
        ssl_ports_t src_filter;
        ssl_ports_t aggr_filter;
        logic [SSL_QUEUES-1:0] cpu_queue_set;
        logic learn_suppress_flag;
    } ssl_frame_t;

    typedef struct packed {
        logic hit;
        logic first_lookup;
        logic action_cpu_copy;
        logic [SSL_QW-1:0] action_cpu_queue_sel;
        logic action_first_hit_copy;
        logic [SSL_HITW-1:0] rule_hit_counter;
        logic learn_suppress;
        logic action_policer_enable;
        logic [SSL_POLW-1:0] action_policer_select;
        logic action_rule_policer_exclusive;
        ssl_mask_mode_t mask_mode;
        ssl_ports_t port_mask;
        logic action_mirror_flag;
    } ssl_action_t;

    typedef struct packed {
        logic [SSL_VW-1:0] virtual_port;
        logic [SSL_LPW-1:0] logical_port;
        logic entry_found;
        logic entry_locked;
        logic [SSL_LPW-1:0] entry_destination_index;
        logic learned_entry_cap;
        logic policed;
        logic source_entry_discard;
        logic source_entry_cpu_copy;
    } ssl_learn_t;

    typedef struct packed {
        logic valid;
        ssl_ports_t destination_port_set;
        logic [SSL_QUEUES-1:0] cpu_queue_set;
        logic learn_suppress_flag;
        logic policer_on;
        logic [SSL_POLW-1:0] policer_select;
        logic rule_policer_exclusive;
        logic mirror;
        logic backbone_table_select;
        logic insert_entry;
        logic normal_learn;
        logic limit_learn;
        logic locked_move;
    } ssl_result_t;
endpackage : ssl_pkg

// [testbench/ssl_upstream_model.sv]
// Earlier pipeline stages and source lookup feeding the forwarding stage
`timescale 1ns/1ps
module ssl_upstream_model
    import ssl_pkg::*;
(
    input wire logic clock,
    input wire logic run,
    output ssl_frame_t frame,
    output ssl_action_t action,
    output ssl_learn_t learn
);
    int seed = 32'h3743;
    logic [127:0] r;
    ssl_frame_t f;
    ssl_action_t a;
    ssl_learn_t l;

    // New pattern every cycle, frames valid only while running
    always @(posedge clock) begin
        r = {$random(seed), $random(seed), $random(seed), $random(seed)};
        f = r[$bits(ssl_frame_t)-1:0];
        a = r[127 -: $bits(ssl_action_t)];
        l = r[100 -: $bits(ssl_learn_t)];
        f.valid = run && (r[127:125] != 3'h0);
        if (r[3])
            a.rule_hit_counter = '0;
        l.logical_port[5:2] = 4'h0;
        l.entry_destination_index[5:2] = 4'h0;
        frame <= f;
        action <= a;
        learn <= l;
    end
endmodule : ssl_upstream_model

// [testbench/ssl_forward_stage_tb.sv]
// Self-checking bench of the forwarding stage against a behavioural model
`timescale 1ns/1ps
module ssl_forward_stage_tb
    import ssl_pkg::*;
;
    logic clock, nrst, reg_wr, reg_rd, run;
    logic [SSL_AW-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, glb;
    ssl_frame_t frame;
    ssl_action_t action;
    ssl_learn_t learn;
    ssl_result_t result;
    logic [16:0] svc [SSL_SERVICES];
    logic [8:0] vp [SSL_VPORTS];
    logic [7:0] c_n, c_l, c_m, c_f;
    ssl_result_t expq [$];
    int tq [$];
    int failures = 0, cmp_count = 0, cycles = 0, seed = 32'h3743;

    ssl_forward_stage u_ssl_forward_stage (.CLOCK(clock), .NRST(nrst), .FRAME_IN(frame),
        .ACTION_IN(action), .LEARN_IN(learn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .RESULT_OUT(result), .REG_RDATA(reg_rdata));
    ssl_upstream_model u_ssl_upstream_model (.clock(clock), .run(run), .frame(frame),
        .action(action), .learn(learn));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk_res(input ssl_result_t got, input ssl_result_t exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_res

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic tbl_clear();
        glb = '0;
        foreach (svc[i]) svc[i] = '0;
        foreach (vp[i]) vp[i] = '0;
        {c_n, c_l, c_m, c_f} = '0;
    endtask : tbl_clear

    function automatic logic [31:0] mirror(input logic [SSL_AW-1:0] ad);
        if (ad == SSL_OFS_GLOBAL)
            return glb;
        if (ad >= SSL_OFS_VIRTUAL_PORT && ad < SSL_OFS_VIRTUAL_PORT_END)
            return {23'h0, vp[(ad - SSL_OFS_VIRTUAL_PORT) >> 2]};
        if (ad >= SSL_OFS_SERVICE && ad < SSL_OFS_SERVICE_END)
            return {15'h0, svc[(ad - SSL_OFS_SERVICE) >> 2]};
        return 32'h0;
    endfunction : mirror

    task automatic reg_wr_t(input logic [SSL_AW-1:0] ad, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        if (ad == SSL_OFS_GLOBAL)
            glb = d;
        if (ad >= SSL_OFS_VIRTUAL_PORT && ad < SSL_OFS_VIRTUAL_PORT_END)
            vp[(ad - SSL_OFS_VIRTUAL_PORT) >> 2] = d[8:0];
        if (ad >= SSL_OFS_SERVICE && ad < SSL_OFS_SERVICE_END)
            svc[(ad - SSL_OFS_SERVICE) >> 2] = d[16:0] & 17'h10fff;
    endtask : reg_wr_t

    task automatic reg_rd_t(input logic [SSL_AW-1:0] ad, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk_val(reg_rdata, exp);
        @(posedge clock);
        #1;
        chk_val(reg_rdata, 32'h0);
    endtask : reg_rd_t

    task automatic cfg();
        logic [SSL_AW-1:0] ad;
        reg_wr_t(SSL_OFS_GLOBAL, $random(seed));
        for (int i = 0; i < SSL_VPORTS; i++) reg_wr_t(SSL_OFS_VIRTUAL_PORT + 12'(4 * i), $random(seed));
        for (int i = 0; i < SSL_SERVICES; i++)
            reg_wr_t(SSL_OFS_SERVICE + 12'(4 * i), $random(seed));
        reg_rd_t(SSL_OFS_GLOBAL, glb);
        for (int i = 0; i < 24; i++) begin
            ad = (i < 16) ? SSL_OFS_VIRTUAL_PORT + 12'(4 * i) : SSL_OFS_SERVICE + 12'($random(seed) & 12'h3fc);
            reg_rd_t(ad, mirror(ad));
        end
        $display("test configure done");
    endtask : cfg

    function automatic ssl_result_t model(ssl_frame_t f, ssl_action_t a, ssl_learn_t l);
        ssl_result_t r;
        logic [16:0] s;
        logic [8:0] v;
        ssl_ports_t d, keep;
        logic [7:0] q;
        logic ok, mv, cand;
        r = '0;
        s = svc[f.service_index];
        keep = s[16] ? (f.src_filter & f.aggr_filter) : s[11:0];
        d = s[16] ? (s[11:0] & keep) : (f.destination_port_set & keep);
        q = f.cpu_queue_set;
        r.learn_suppress_flag = f.learn_suppress_flag;
        if (a.hit) begin
            if (a.action_cpu_copy || (a.action_first_hit_copy && a.rule_hit_counter == 0))
                q[a.action_cpu_queue_sel] = 1'b1;
            r.learn_suppress_flag |= a.learn_suppress;
            r.policer_on = a.first_lookup & a.action_policer_enable;
            r.policer_select = r.policer_on ? a.action_policer_select : '0;
            r.rule_policer_exclusive = a.first_lookup & a.action_rule_policer_exclusive;
            case (a.mask_mode)
                SSL_MM_PERMIT: d &= a.port_mask;
                SSL_MM_POLICY: d = a.port_mask & keep & (s[16] ? keep : f.post_dmac_filter);
                SSL_MM_REDIRECT: d = a.port_mask;
                default: ;
            endcase
            r.mirror = a.action_mirror_flag;
        end
        v = vp[l.virtual_port];
        r.backbone_table_select = v[8];
        ok = v[0] && !r.learn_suppress_flag && !l.policed;
        mv = l.entry_destination_index != l.logical_port;
        cand = !l.entry_found || (!l.entry_locked && mv);
        r.normal_learn = ok && cand && !l.learned_entry_cap;
        r.limit_learn = ok && cand && l.learned_entry_cap;
        r.locked_move = ok && l.entry_found && l.entry_locked && mv;
        r.insert_entry = r.normal_learn && v[1];
        for (int k = 0; k < 3; k++) begin
            if ({r.locked_move, r.limit_learn, r.normal_learn} == 3'(1 << k)) begin
                if (v[3 + 2 * k])
                    d = '0;
                if (v[2 + 2 * k]) begin
                    d[SSL_CPU_PORT] = 1'b1;
                    q[(k == 2) ? glb[6:4] : glb[2:0]] = 1'b1;
                end
            end
        end
        if (l.entry_found && !glb[16]) begin
            if (l.source_entry_discard)
                d = '0;
            if (l.source_entry_cpu_copy)
                q[glb[10:8]] = 1'b1;
        end
        r.valid = 1'b1;
        r.destination_port_set = d;
        r.cpu_queue_set = q;
        return r;
    endfunction : model

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end else if (!nrst) begin
            expq.delete();
            tq.delete();
        end else begin
            if (result.valid === 1'b1 && expq.size() == 0) begin
                failures++;
                $display("BAD t=%0t got=%h exp=%h", $time, result, 0);
            end else if (result.valid === 1'b1) begin
                chk_res(result, expq.pop_front());
                chk_val(32'(cycles - tq.pop_front()), 32'h3);
            end
            if (frame.valid === 1'b1) begin
                expq.push_back(model(frame, action, learn));
                tq.push_back(cycles);
                c_f++;
                c_n += 8'(expq[$].normal_learn);
                c_l += 8'(expq[$].limit_learn);
                c_m += 8'(expq[$].locked_move);
            end
        end
    end

    task automatic frames(input int n);
        @(posedge clock);
        run <= 1'b1;
        repeat (n) @(posedge clock);
        run <= 1'b0;
        repeat (8) @(posedge clock);
        chk_val(32'(expq.size()), 32'h0);
        reg_rd_t(SSL_OFS_STATUS, {c_f, c_m, c_l, c_n});
        $display("test frames done");
    endtask : frames

    initial begin
        nrst = 1'b0;
        run = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tbl_clear();
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) reg_rd_t(SSL_OFS_GLOBAL + 12'(4 * i), 32'h0);
        reg_rd_t(SSL_OFS_SERVICE + 12'h3fc, 32'h0);
        reg_wr_t(SSL_OFS_STATUS, 32'hffff_ffff);
        reg_wr_t(SSL_OFS_SERVICE_END, 32'hffff_ffff);
        reg_rd_t(SSL_OFS_STATUS, 32'h0);
        reg_rd_t(SSL_OFS_SERVICE_END, 32'h0);
        reg_rd_t(SSL_OFS_VIRTUAL_PORT_END, 32'h0);
        $display("test reset and map done");
        cfg();
        frames(1500);
        cfg();
        frames(1500);
        @(posedge clock);
        run <= 1'b1;
        repeat (20) @(posedge clock);
        nrst <= 1'b0;
        run <= 1'b0;
        repeat (3) @(posedge clock);
        tbl_clear();
        nrst <= 1'b1;
        reg_rd_t(SSL_OFS_STATUS, 32'h0);
        reg_rd_t(SSL_OFS_SERVICE + 12'h010, 32'h0);
        frames(200);
        $display("test second reset done");
        give_verdict();
    end
endmodule : ssl_forward_stage_tb
